// ### rtl/cbu_cond.sv
// Shared constants and the branch condition evaluator for the compact branch unit.
`default_nettype none

package cbu_pkg;
   localparam int DATA_W = 32;
   localparam int OPC_MSB = 31;
   localparam int OPC_LSB = 26;
   localparam int HI_MSB = 25;
   localparam int HI_LSB = 21;
   localparam int LO_MSB = 20;
   localparam int LO_LSB = 16;
   localparam int OFF_SHORT_W = 16;
   localparam int OFF_LONG_W = 21;
   localparam int OFF_UNCOND_W = 26;
   localparam int OFFSET_SHIFT = 1;
   localparam logic [5:0] OP_ZERO_LONG = 6'h20;
   localparam logic [5:0] OP_NONZERO_LONG = 6'h28;
   localparam logic [5:0] OP_SIGNED_GE = 6'h3D;
   localparam logic [5:0] OP_SIGNED_LT = 6'h35;
   localparam logic [5:0] OP_UNSIGNED_GE = 6'h30;
   localparam logic [5:0] OP_UNSIGNED_LT = 6'h38;
   localparam logic [5:0] OP_EQUAL = 6'h1D;
   localparam logic [5:0] OP_UNEQUAL = 6'h1F;
   localparam logic [5:0] OP_UNCOND_DEFAULT = 6'h25;
   localparam logic [4:0] FIELD_ZERO = 5'h00;
   localparam logic [4:0] LINK_REG = 5'h1F;
   localparam logic [31:0] INSTR_BYTES = 32'h00000004;
   localparam logic [31:0] WORD_ZERO = 32'h00000000;

   typedef enum logic [3:0] {
      CBU_NONE = 4'b0000,
      CBU_EQ = 4'b0001,
      CBU_NE = 4'b0010,
      CBU_SLT = 4'b0011,
      CBU_SGE = 4'b0100,
      CBU_ULT = 4'b0101,
      CBU_UGE = 4'b0110,
      CBU_LTZ = 4'b0111,
      CBU_LEZ = 4'b1000,
      CBU_GEZ = 4'b1001,
      CBU_GTZ = 4'b1010,
      CBU_EQZ = 4'b1011,
      CBU_NEZ = 4'b1100,
      CBU_ALWAYS = 4'b1101
   } cbu_cond_t;
endpackage

// Pure combinational compare; first is the low field register, second the high one.
module cbu_cond (
   input wire cbu_pkg::cbu_cond_t kind_in,
   input wire logic [31:0] first_in,
   input wire logic [31:0] second_in,
   input wire logic [31:0] zero_test_in,
   output logic taken_out
);
   always_comb begin
      case (kind_in)
         cbu_pkg::CBU_EQ: taken_out = (first_in == second_in);
         cbu_pkg::CBU_NE: taken_out = (first_in != second_in);
         cbu_pkg::CBU_SLT: taken_out = ($signed(first_in) < $signed(second_in));
         cbu_pkg::CBU_SGE: taken_out = ($signed(first_in) >= $signed(second_in));
         cbu_pkg::CBU_ULT: taken_out = (first_in < second_in);
         cbu_pkg::CBU_UGE: taken_out = (first_in >= second_in);
         cbu_pkg::CBU_LTZ: taken_out = zero_test_in[31];
         cbu_pkg::CBU_LEZ: taken_out = zero_test_in[31] || (zero_test_in == cbu_pkg::WORD_ZERO);
         cbu_pkg::CBU_GEZ: taken_out = !zero_test_in[31];
         cbu_pkg::CBU_GTZ: taken_out = !zero_test_in[31] && (zero_test_in != cbu_pkg::WORD_ZERO);
         cbu_pkg::CBU_EQZ: taken_out = (zero_test_in == cbu_pkg::WORD_ZERO);
         cbu_pkg::CBU_NEZ: taken_out = (zero_test_in != cbu_pkg::WORD_ZERO);
         cbu_pkg::CBU_ALWAYS: taken_out = 1'b1;
         default: taken_out = 1'b0;
      endcase
   end
endmodule

`default_nettype wire

// ### rtl/cbu_branch_unit.sv
// Compact branch decode, evaluation, target and link generation.
`default_nettype none
// What this block does
// RULE_01: Every link compare-to-zero branch writes the next address to register 31.
// RULE_02: Link family compares the register signed against zero, six variants.
// RULE_03: Equal branch taken on identical registers; unequal one when they differ.
// RULE_04: Signed register compares: less-than when first smaller, otherwise greater-equal.
// RULE_05: Unsigned register compares branch on less-than or greater-equal magnitude.
// RULE_06: Short-offset zero compares test one register signed against zero.
// RULE_07: Long-offset branches test one register for zero or nonzero.
// RULE_08: Long zero-equality forms use 21-bit offsets, other compares 16-bit.
// RULE_09: Target is next address plus sign-extended scaled offset; one-bit shift chosen.
// RULE_10: No delay slot: a taken branch squashes the following instruction.
// RULE_11: Any instruction may follow a compact branch, with no stall.
// RULE_12: Unconditional branch adds its 26-bit offset shifted one, sign-extended.
// RULE_13: Opcode is bits 31-26, and register fields also steer the decode.
// RULE_14: Long zero branches decode from their two opcodes only with nonzero field.
// RULE_15: Shared opcodes split on zero field, equal fields, or differing fields.
// RULE_16: No exception is raised by any of these branches.
module cbu_branch_unit #(
   parameter logic [5:0] UNCOND_OPCODE = cbu_pkg::OP_UNCOND_DEFAULT
) (
   // Clock and reset.
   input wire logic CLK_IN,
   input wire logic RESET_IN,
   // Decoded instruction and its operands.
   input wire logic VALID_IN,
   input wire logic [31:0] INSTR_IN,
   input wire logic [31:0] PC_IN,
   input wire logic [31:0] OPERAND_HI_IN,
   input wire logic [31:0] OPERAND_LO_IN,
   // Branch resolution.
   output logic RESULT_VALID_OUT,
   output logic BRANCH_VALID_OUT,
   output logic TAKEN_OUT,
   output logic SQUASH_NEXT_OUT,
   output logic [31:0] TARGET_OUT,
   output logic [31:0] NEXT_PC_OUT,
   // Return link write.
   output logic LINK_WRITE_OUT,
   output logic [4:0] LINK_REG_OUT,
   output logic [31:0] LINK_DATA_OUT,
   // Fault report.
   output logic EXCEPTION_OUT
);
   // Sign-extends the low bits of a raw offset field and scales it.
   function automatic logic [31:0] scaled_offset(input logic [25:0] raw, input int bits);
      logic [31:0] ext;
      ext = {6'h00, raw};
      // Only the sign bit is indexed by a variable, so no read falls outside the field.
      for (int i = 0; i < 32; i++) begin
         if (i >= bits) begin
            ext[i] = raw[bits - 1];
         end
      end
      return ext << cbu_pkg::OFFSET_SHIFT;
   endfunction

   logic [5:0] opcode;
   logic [4:0] field_hi;
   logic [4:0] field_lo;
   logic hi_zero;
   logic lo_zero;
   cbu_pkg::cbu_cond_t kind;
   logic is_link;
   int off_bits;
   logic cond_taken;
   logic [31:0] after_pc;
   logic [31:0] target;
   logic result_valid_reg, result_valid_next;
   logic branch_valid_reg, branch_valid_next;
   logic taken_reg, taken_next;
   logic [31:0] target_reg, target_next;
   logic [31:0] next_pc_reg, next_pc_next;
   logic link_write_reg, link_write_next;
   logic [31:0] link_data_reg, link_data_next;

   assign opcode = INSTR_IN[cbu_pkg::OPC_MSB:cbu_pkg::OPC_LSB]; // RULE_13
   assign field_hi = INSTR_IN[cbu_pkg::HI_MSB:cbu_pkg::HI_LSB];
   assign field_lo = INSTR_IN[cbu_pkg::LO_MSB:cbu_pkg::LO_LSB];
   assign hi_zero = (field_hi == cbu_pkg::FIELD_ZERO);
   assign lo_zero = (field_lo == cbu_pkg::FIELD_ZERO);

   // Forms whose high field is zero belong to older instructions and are left alone; the unconditional branch decodes whatever its bits 25-21 hold.
   always_comb begin
      kind = cbu_pkg::CBU_NONE;
      is_link = 1'b0;
      off_bits = cbu_pkg::OFF_SHORT_W; // RULE_08
      case (opcode)
         cbu_pkg::OP_SIGNED_GE: begin
            if (!hi_zero) begin
               if (lo_zero) kind = cbu_pkg::CBU_LEZ; // RULE_06 RULE_15
               else if (field_lo == field_hi) kind = cbu_pkg::CBU_GEZ; // RULE_06 RULE_15
               else kind = cbu_pkg::CBU_SGE; // RULE_04 RULE_15
            end
         end
         cbu_pkg::OP_SIGNED_LT: begin
            if (!hi_zero) begin
               if (lo_zero) kind = cbu_pkg::CBU_GTZ; // RULE_06
               else if (field_lo == field_hi) kind = cbu_pkg::CBU_LTZ; // RULE_06
               else kind = cbu_pkg::CBU_SLT; // RULE_04
            end
         end
         cbu_pkg::OP_UNSIGNED_GE: begin
            if (!hi_zero) begin
               if (lo_zero) kind = cbu_pkg::CBU_LEZ; // RULE_02
               else if (field_lo == field_hi) kind = cbu_pkg::CBU_GEZ; // RULE_02
               else kind = cbu_pkg::CBU_UGE; // RULE_05
               is_link = lo_zero || (field_lo == field_hi); // RULE_01
            end
         end
         cbu_pkg::OP_UNSIGNED_LT: begin
            if (!hi_zero) begin
               if (lo_zero) kind = cbu_pkg::CBU_GTZ; // RULE_02
               else if (field_lo == field_hi) kind = cbu_pkg::CBU_LTZ; // RULE_02
               else kind = cbu_pkg::CBU_ULT; // RULE_05
               is_link = lo_zero || (field_lo == field_hi); // RULE_01
            end
         end
         cbu_pkg::OP_EQUAL: begin
            // Fields with the low field at or above the high one encode the overflow branch, which lives elsewhere.
            if (!hi_zero && field_lo < field_hi) begin
               kind = lo_zero ? cbu_pkg::CBU_EQZ : cbu_pkg::CBU_EQ; // RULE_02 RULE_03
               is_link = lo_zero; // RULE_01
            end
         end
         cbu_pkg::OP_UNEQUAL: begin
            if (!hi_zero && field_lo < field_hi) begin
               kind = lo_zero ? cbu_pkg::CBU_NEZ : cbu_pkg::CBU_NE; // RULE_02 RULE_03
               is_link = lo_zero; // RULE_01
            end
         end
         cbu_pkg::OP_ZERO_LONG: begin
            if (!hi_zero) kind = cbu_pkg::CBU_EQZ; // RULE_07 RULE_14
            off_bits = cbu_pkg::OFF_LONG_W; // RULE_08
         end
         cbu_pkg::OP_NONZERO_LONG: begin
            if (!hi_zero) kind = cbu_pkg::CBU_NEZ; // RULE_07 RULE_14
            off_bits = cbu_pkg::OFF_LONG_W; // RULE_08
         end
         default: begin
            if (opcode == UNCOND_OPCODE) begin
               kind = cbu_pkg::CBU_ALWAYS; // RULE_12
               off_bits = cbu_pkg::OFF_UNCOND_W; // RULE_12
            end
         end
      endcase
   end

   // Zero tests always look at the high field register.
   cbu_cond u_cond (
      .kind_in(kind),
      .first_in(OPERAND_LO_IN),
      .second_in(OPERAND_HI_IN),
      .zero_test_in(OPERAND_HI_IN),
      .taken_out(cond_taken)
   );

   assign after_pc = PC_IN + cbu_pkg::INSTR_BYTES;
   assign target = after_pc + scaled_offset(INSTR_IN[25:0], off_bits); // RULE_09

   always_comb begin
      result_valid_next = VALID_IN; // RULE_11
      branch_valid_next = VALID_IN && (kind != cbu_pkg::CBU_NONE);
      taken_next = branch_valid_next && cond_taken;
      target_next = target;
      next_pc_next = taken_next ? target : after_pc; // RULE_10
      link_write_next = VALID_IN && is_link; // RULE_01
      link_data_next = after_pc; // RULE_01
   end

   always_ff @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         result_valid_reg <= 1'b0;
         branch_valid_reg <= 1'b0;
         taken_reg <= 1'b0;
         target_reg <= cbu_pkg::WORD_ZERO;
         next_pc_reg <= cbu_pkg::WORD_ZERO;
         link_write_reg <= 1'b0;
         link_data_reg <= cbu_pkg::WORD_ZERO;
      end else begin
         result_valid_reg <= result_valid_next;
         branch_valid_reg <= branch_valid_next;
         taken_reg <= taken_next;
         target_reg <= target_next;
         next_pc_reg <= next_pc_next;
         link_write_reg <= link_write_next;
         link_data_reg <= link_data_next;
      end
   end

   assign RESULT_VALID_OUT = result_valid_reg;
   assign BRANCH_VALID_OUT = branch_valid_reg;
   assign TAKEN_OUT = taken_reg;
   assign SQUASH_NEXT_OUT = taken_reg; // RULE_10
   assign TARGET_OUT = target_reg;
   assign NEXT_PC_OUT = next_pc_reg;
   assign LINK_WRITE_OUT = link_write_reg;
   assign LINK_REG_OUT = cbu_pkg::LINK_REG;
   assign LINK_DATA_OUT = link_data_reg;
   assign EXCEPTION_OUT = 1'b0; // RULE_16

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RESET_IN);

   logic [5:0] op_w;
   logic hi_nz_w;
   assign op_w = INSTR_IN[31:26];
   assign hi_nz_w = (INSTR_IN[25:21] != 5'h00);

   sequence s_link_req;
      VALID_IN && hi_nz_w && (((op_w == cbu_pkg::OP_UNSIGNED_GE || op_w == cbu_pkg::OP_UNSIGNED_LT)
         && (INSTR_IN[20:16] == 5'h00 || INSTR_IN[20:16] == INSTR_IN[25:21]))
         || ((op_w == cbu_pkg::OP_EQUAL || op_w == cbu_pkg::OP_UNEQUAL) && INSTR_IN[20:16] == 5'h00));
   endsequence
   sequence s_link_done;
      LINK_WRITE_OUT && LINK_REG_OUT == 5'h1F && LINK_DATA_OUT == $past(PC_IN) + 32'h00000004;
   endsequence
   property p_link_always;
      s_link_req |=> s_link_done;
   endproperty
   a_link_always: assert property (p_link_always) else $error("Link not written."); // RULE_01

   property p_link_below_zero;
      VALID_IN && op_w == cbu_pkg::OP_UNSIGNED_LT && hi_nz_w && INSTR_IN[20:16] == INSTR_IN[25:21]
         |=> BRANCH_VALID_OUT && TAKEN_OUT == $past(OPERAND_HI_IN[31]);
   endproperty
   a_link_below_zero: assert property (p_link_below_zero) else $error("Link below-zero wrong."); // RULE_02

   property p_equal_regs;
      VALID_IN && op_w == cbu_pkg::OP_EQUAL && INSTR_IN[20:16] != 5'h00
         && INSTR_IN[20:16] < INSTR_IN[25:21]
         |=> TAKEN_OUT == ($past(OPERAND_HI_IN) == $past(OPERAND_LO_IN));
   endproperty
   a_equal_regs: assert property (p_equal_regs) else $error("Equal compare wrong."); // RULE_03

   property p_signed_less;
      VALID_IN && op_w == cbu_pkg::OP_SIGNED_LT && hi_nz_w && INSTR_IN[20:16] != 5'h00
         && INSTR_IN[20:16] != INSTR_IN[25:21]
         |=> TAKEN_OUT == ($signed($past(OPERAND_LO_IN)) < $signed($past(OPERAND_HI_IN)))
         && TARGET_OUT == $past(PC_IN) + 32'h00000004
         + {{15{$past(INSTR_IN[15])}}, $past(INSTR_IN[15:0]), 1'b0};
   endproperty
   a_signed_less: assert property (p_signed_less) else $error("Signed compare wrong."); // RULE_04 RULE_09

   property p_unsigned_ge;
      VALID_IN && op_w == cbu_pkg::OP_UNSIGNED_GE && hi_nz_w && INSTR_IN[20:16] != 5'h00
         && INSTR_IN[20:16] != INSTR_IN[25:21]
         |=> !LINK_WRITE_OUT && TAKEN_OUT == ($past(OPERAND_LO_IN) >= $past(OPERAND_HI_IN));
   endproperty
   a_unsigned_ge: assert property (p_unsigned_ge) else $error("Unsigned compare wrong."); // RULE_05

   property p_at_most_zero;
      VALID_IN && op_w == cbu_pkg::OP_SIGNED_GE && hi_nz_w && INSTR_IN[20:16] == 5'h00
         |=> TAKEN_OUT == ($signed($past(OPERAND_HI_IN)) <= 0);
   endproperty
   a_at_most_zero: assert property (p_at_most_zero) else $error("Zero compare wrong."); // RULE_06

   property p_zero_long;
      VALID_IN && op_w == cbu_pkg::OP_ZERO_LONG && hi_nz_w
         |=> TAKEN_OUT == ($past(OPERAND_HI_IN) == 32'h00000000)
         && TARGET_OUT == $past(PC_IN) + 32'h00000004
         + {{10{$past(INSTR_IN[20])}}, $past(INSTR_IN[20:0]), 1'b0};
   endproperty
   a_zero_long: assert property (p_zero_long) else $error("Long zero branch wrong."); // RULE_07 RULE_08 RULE_14

   property p_legacy_form;
      VALID_IN && !hi_nz_w && op_w != UNCOND_OPCODE |=> !BRANCH_VALID_OUT && !LINK_WRITE_OUT;
   endproperty
   a_legacy_form: assert property (p_legacy_form) else $error("Legacy form decoded."); // RULE_13 RULE_15

   property p_uncond;
      VALID_IN && op_w == UNCOND_OPCODE |=> TAKEN_OUT && NEXT_PC_OUT == $past(PC_IN)
         + 32'h00000004 + {{5{$past(INSTR_IN[25])}}, $past(INSTR_IN[25:0]), 1'b0};
   endproperty
   a_uncond: assert property (p_uncond) else $error("Unconditional target wrong."); // RULE_12

   property p_no_slot;
      RESULT_VALID_OUT |-> SQUASH_NEXT_OUT == TAKEN_OUT
         && (TAKEN_OUT ? NEXT_PC_OUT == TARGET_OUT : NEXT_PC_OUT == $past(PC_IN) + 32'h00000004);
   endproperty
   a_no_slot: assert property (p_no_slot) else $error("Delay slot handling wrong."); // RULE_10

   property p_back_to_back;
      VALID_IN ##1 VALID_IN |=> RESULT_VALID_OUT && $past(RESULT_VALID_OUT);
   endproperty
   a_back_to_back: assert property (p_back_to_back) else $error("Back-to-back dropped."); // RULE_11

   property p_no_fault;
      !EXCEPTION_OUT;
   endproperty
   a_no_fault: assert property (p_no_fault) else $error("Exception raised."); // RULE_16
endmodule

`default_nettype wire

// ### test/cbu_regfile_model.sv
// Register file model that feeds operands to the branch unit and takes its link writes.
`default_nettype none
module cbu_regfile_model (
   // Clock.
   input wire logic clk_in,
   // Operand selection and read data.
   input wire logic [31:0] instr_in,
   output logic [31:0] operand_hi_out,
   output logic [31:0] operand_lo_out,
   // Return link write.
   input wire logic link_write_in,
   input wire logic [4:0] link_reg_in,
   input wire logic [31:0] link_data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] regs [32];
   // Register zero reads as zero, so zero-field forms see a true zero operand.
   assign operand_hi_out = (instr_in[25:21] == 5'h00) ? 32'h00000000 : regs[instr_in[25:21]];
   assign operand_lo_out = (instr_in[20:16] == 5'h00) ? 32'h00000000 : regs[instr_in[20:16]];
   initial begin
      for (int i = 0; i < 32; i++) begin
         regs[i] = 32'h00000000;
      end
   end
   task automatic load(input logic [4:0] idx, input logic [31:0] val);
      regs[idx] = val;
   endtask
   always @(posedge clk_in) begin
      if (link_write_in) begin
         regs[link_reg_in] <= link_data_in;
      end
   end
endmodule
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench that streams compact branches back to back through the unit.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, valid, res_valid, br_valid, taken, squash, link_wr, exc;
   logic [31:0] instr, pc, op_hi, op_lo, target, next_pc, link_data;
   logic [4:0] link_reg;
   logic p_v, p_br, p_tk, p_lk;
   logic [31:0] p_pc, p_tgt;
   int error_cnt, comparisons;

   cbu_branch_unit dut_u (
      .CLK_IN(clk), .RESET_IN(rst), .VALID_IN(valid), .INSTR_IN(instr), .PC_IN(pc),
      .OPERAND_HI_IN(op_hi), .OPERAND_LO_IN(op_lo), .RESULT_VALID_OUT(res_valid),
      .BRANCH_VALID_OUT(br_valid), .TAKEN_OUT(taken), .SQUASH_NEXT_OUT(squash),
      .TARGET_OUT(target), .NEXT_PC_OUT(next_pc), .LINK_WRITE_OUT(link_wr),
      .LINK_REG_OUT(link_reg), .LINK_DATA_OUT(link_data), .EXCEPTION_OUT(exc)
   );
   cbu_regfile_model rf_u (
      .clk_in(clk), .instr_in(instr), .operand_hi_out(op_hi), .operand_lo_out(op_lo),
      .link_write_in(link_wr), .link_reg_in(link_reg), .link_data_in(link_data)
   );

   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_prev();
      chk("result_valid", 32'(p_v), 32'(res_valid));
      chk("exception", 32'h00000000, 32'(exc));
      chk("link_write", 32'(p_lk), 32'(link_wr));
      if (p_v) begin
         chk("branch_valid", 32'(p_br), 32'(br_valid));
         chk("taken", 32'(p_tk), 32'(taken));
         chk("squash", 32'(p_tk), 32'(squash));
         chk("next_pc", p_tk ? p_tgt : p_pc + 32'h00000004, next_pc);
         if (p_br) chk("target", p_tgt, target);
         if (p_lk) chk("link_data", p_pc + 32'h00000004, link_data);
         chk("link_reg", 32'h0000001F, 32'(link_reg));
      end
   endtask

   // Offset width w of 0 sends a bubble; e packs branch, taken and link expectations.
   task automatic step(input logic [5:0] op, input logic [4:0] hi, input logic [4:0] lo,
                       input int w, input logic [25:0] off, input logic [2:0] e);
      logic [31:0] s;
      @(negedge clk);
      check_prev();
      s = 32'(off) << (32 - w);
      s = $signed(s) >>> (31 - w);
      pc = pc + 32'h00000004;
      case (w)
         16: instr = {op, hi, lo, off[15:0]};
         21: instr = {op, hi, off[20:0]};
         default: instr = {op, off};
      endcase
      valid = (w != 0);
      p_v = valid;
      p_br = e[2] & valid;
      p_tk = e[1] & valid;
      p_lk = e[0] & valid;
      p_pc = pc;
      p_tgt = pc + 32'h00000004 + s;
   endtask

   task automatic test_done();
      $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      #200000;
      error_cnt++;
      $display("[ERR] run_time expected finish seen hang");
      test_done();
   end

   initial begin
      error_cnt = 0;
      comparisons = 0;
      rst = 1'h1;
      valid = 1'h0;
      instr = 32'h00000000;
      pc = 32'h00001000;
      {p_v, p_br, p_tk, p_lk} = 4'h0;
      repeat (8) @(negedge clk);
      chk("reset_valid", 32'h00000000, 32'(res_valid));
      rst = 1'h0;
      rf_u.load(5'h01, 32'h00000005);
      rf_u.load(5'h02, 32'hFFFFFFFF);
      rf_u.load(5'h04, 32'h00000005);
      rf_u.load(5'h05, 32'h80000000);
      rf_u.load(5'h06, 32'h00000001);
      step(6'h00, 5'h00, 5'h00, 0, 26'h0, 3'h0);
      step(6'h35, 5'h01, 5'h02, 16, 26'h0010, 3'h6);
      step(6'h35, 5'h02, 5'h01, 16, 26'h8000, 3'h4);
      step(6'h3D, 5'h02, 5'h01, 16, 26'h7FFF, 3'h6);
      step(6'h38, 5'h01, 5'h02, 16, 26'h0002, 3'h4);
      step(6'h38, 5'h02, 5'h01, 16, 26'hFFFE, 3'h6);
      step(6'h30, 5'h01, 5'h02, 16, 26'h0100, 3'h6);
      step(6'h1D, 5'h04, 5'h01, 16, 26'h0004, 3'h6);
      step(6'h1F, 5'h04, 5'h01, 16, 26'h0004, 3'h4);
      step(6'h1D, 5'h02, 5'h01, 16, 26'h0008, 3'h4);
      step(6'h1F, 5'h02, 5'h01, 16, 26'h0008, 3'h6);
      step(6'h1D, 5'h04, 5'h05, 16, 26'h0008, 3'h0);
      step(6'h3D, 5'h03, 5'h00, 16, 26'h0020, 3'h6);
      step(6'h3D, 5'h05, 5'h05, 16, 26'h0020, 3'h4);
      step(6'h35, 5'h06, 5'h00, 16, 26'h0020, 3'h6);
      step(6'h35, 5'h03, 5'h03, 16, 26'h0020, 3'h4);
      step(6'h30, 5'h02, 5'h00, 16, 26'h0040, 3'h7);
      step(6'h30, 5'h03, 5'h03, 16, 26'h0040, 3'h7);
      step(6'h38, 5'h03, 5'h00, 16, 26'h0040, 3'h5);
      step(6'h38, 5'h05, 5'h05, 16, 26'h0040, 3'h7);
      step(6'h1D, 5'h03, 5'h00, 16, 26'h0040, 3'h7);
      step(6'h1F, 5'h03, 5'h00, 16, 26'h0040, 3'h5);
      step(6'h00, 5'h00, 5'h00, 0, 26'h0, 3'h0);
      step(6'h20, 5'h03, 5'h00, 21, 26'h100000, 3'h6);
      step(6'h28, 5'h03, 5'h00, 21, 26'h0FFFFF, 3'h4);
      step(6'h28, 5'h01, 5'h00, 21, 26'h0FFFFF, 3'h6);
      step(6'h20, 5'h00, 5'h00, 21, 26'h000010, 3'h0);
      step(6'h25, 5'h00, 5'h00, 26, 26'h2000000, 3'h6);
      step(6'h25, 5'h00, 5'h00, 26, 26'h1FFFFFF, 3'h6);
      step(6'h3D, 5'h00, 5'h02, 16, 26'h0010, 3'h0);
      step(6'h00, 5'h01, 5'h02, 16, 26'h0010, 3'h0);
      step(6'h00, 5'h00, 5'h00, 0, 26'h0, 3'h0);
      @(negedge clk);
      check_prev();
      test_done();
   end
endmodule
`default_nettype wire
